// ===== core/ocs_pkg.sv
// Constants, register map and types of the clock synthesis control block.
package ocs_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
	localparam int INT_OSC_HZ = 8_000_000;
	localparam int MAX_SYS_HZ = 32_000_000;
	localparam int PLL_MULT = 8;
	localparam int LOR_TIME_NS = 1000;
	localparam int LOR_CYCLES = (LOR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] LOR_LIMIT = 6'(LOR_CYCLES);

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OSC = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h0C;
	localparam logic [7:0] REG_SHUTDN = 8'h10;

	localparam int CTRL_PLL_SEL = 0;
	localparam int CTRL_PLL_PD = 1;
	localparam int CTRL_PS_LSB = 2;
	localparam int OSC_EXT = 0;
	localparam int OSC_PD = 1;
	localparam int OSC_STBY = 2;
	localparam int ST_LOCK = 0;
	localparam int ST_UNLOCK = 1;
	localparam int ST_REFLOST = 2;
	localparam int ST_LIVE_LOCK = 8;
	localparam int ST_REF_EXT = 9;
	localparam int ST_PLL_ON = 10;
	localparam int ST_SHUT = 11;
	localparam int SDN_EN = 0;

	localparam logic RST_PLL_SEL = 1'b0;
	localparam logic RST_PLL_PD = 1'b1;
	localparam logic [2:0] RST_PS = 3'h0;
	localparam logic RST_OSC_EXT = 1'b0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {OCS_SW_RUN, OCS_SW_WAIT} ocs_sw_state_t;
endpackage : ocs_pkg

// ===== core/ocs_clk_switch.sv
// Glitch-free two-way clock selector sampled on the system clock.
`timescale 1ns/1ns
module ocs_clk_switch (
	input wire logic clk,
	input wire logic rst,
	input wire logic src0,
	input wire logic src1,
	input wire logic sel,
	output logic clk_out,
	output logic cur_sel
);
	typedef struct packed {
		ocs_pkg::ocs_sw_state_t st;
		logic cur;
		logic y;
	} ocs_sw_t;

	ocs_sw_t s;
	ocs_sw_t next_s;
	logic src_cur;

	// The old source is left only while it is low, and the new one is
	// passed on only from a low phase, so no pulse is ever cut short.
	always_comb begin
		next_s = s;
		src_cur = s.cur ? src1 : src0;
		case (s.st)
		ocs_pkg::OCS_SW_RUN: begin
			next_s.y = src_cur;
			if (sel != s.cur && !src_cur) begin
				next_s.cur = sel;
				next_s.st = ocs_pkg::OCS_SW_WAIT;
			end
		end
		ocs_pkg::OCS_SW_WAIT: begin
			next_s.y = 1'b0;
			if (!src_cur) begin
				next_s.st = ocs_pkg::OCS_SW_RUN;
			end
		end
		default: begin
			next_s.st = ocs_pkg::OCS_SW_RUN;
			next_s.y = 1'b0;
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign clk_out = s.y;
	assign cur_sel = s.cur;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	rise_from_src_a: assert property (
		$rose(clk_out) |-> $past(s.st == ocs_pkg::OCS_SW_RUN && src_cur))
		else $error("Selector output rose without its source high.");
	fall_with_src_a: assert property (
		$fell(clk_out) |-> $past(!src_cur))
		else $error("Selector output fell while its source was high.");
endmodule : ocs_clk_switch

// ===== core/ocs_clock_synth.sv
// Clock synthesis control: reference and PLL path selection and registers.
`timescale 1ns/1ns
module ocs_clock_synth (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic osc_int_in,
	input wire logic ext_clock_in,
	input wire logic pll_vco_in,
	input wire logic pll_3x_in,
	input wire logic pll_lock_in,
	output logic sys2x_clk,
	output logic timer_clk3x,
	output logic osc_clk_out,
	output logic adc_clk,
	output logic hsp_clk,
	output logic osc_powerdown,
	output logic osc_standby,
	output logic pll_powerdown,
	output logic irq
);
	typedef struct packed {
		logic awready, wready, bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic wlane0, pll_sel, pll_pd;
		logic [2:0] ps;
		logic osc_ext, osc_pd, osc_stby;
		logic [2:0] sts;
		logic [2:0] mask;
		logic sdn_en, shut, ref_q;
		logic [5:0] lor_cnt;
		logic lock_q, vco_q, v3_q;
		logic [4:0] d2_cnt;
		logic d2_out;
		logic [4:0] d3_cnt;
		logic d3_out;
		logic sys2x, t3x, oscclk, adc, irq;
	} ocs_state_t;

	ocs_state_t s;
	ocs_state_t next_s;

	logic ref_int, vco, vco3, ref_clk, ref_cur, pll_use;
	logic p2_y, p2_cur, p3_y, p3_cur, ref_rise, vco_rise, wr_go;
	logic [2:0] sts_set, sts_clr;
	logic [5:0] div_step;

	// Half of the postscaler ratio; zero means divide by one.
	function automatic logic [4:0] ocs_half(input logic [2:0] code);
		case (code)
		3'h0: ocs_half = 5'h00;
		3'h1: ocs_half = 5'h01;
		3'h2: ocs_half = 5'h02;
		3'h3: ocs_half = 5'h04;
		3'h4: ocs_half = 5'h08;
		default: ocs_half = 5'h10;
		endcase
	endfunction : ocs_half

	// One step of a postscaler: returns the new output and count.
	function automatic logic [5:0] ocs_div(input logic lvl, input logic rise,
		input logic [2:0] code, input logic out, input logic [4:0] cnt);
		logic [4:0] half;
		half = ocs_half(code);
		ocs_div = {out, cnt};
		if (half == 5'h00) begin
			ocs_div = {lvl, 5'h00};
		end else if (rise) begin
			if (cnt + 5'h01 >= half) begin
				ocs_div = {!out, 5'h00};
			end else begin
				ocs_div = {out, cnt + 5'h01};
			end
		end
	endfunction : ocs_div

	function automatic logic ocs_mapped(input logic [7:0] addr);
		ocs_mapped = addr == ocs_pkg::REG_CTRL || addr == ocs_pkg::REG_OSC ||
			addr == ocs_pkg::REG_STATUS || addr == ocs_pkg::REG_MASK ||
			addr == ocs_pkg::REG_SHUTDN;
	endfunction : ocs_mapped

	// A powered-down or parked oscillator delivers no edges.
	assign ref_int = osc_int_in && !s.osc_pd && !s.osc_stby;
	assign vco = pll_vco_in && !s.pll_pd;
	assign vco3 = pll_3x_in && !s.pll_pd;
	assign pll_use = s.pll_sel && pll_lock_in && !s.pll_pd;

	ocs_clk_switch u_ref_sel (
		.clk(clk),
		.rst(rst),
		.src0(ref_int),
		.src1(ext_clock_in),
		.sel(s.osc_ext),
		.clk_out(ref_clk),
		.cur_sel(ref_cur)
	);

	ocs_clk_switch u_path2x (
		.clk(clk),
		.rst(rst),
		.src0(ref_clk),
		.src1(s.d2_out),
		.sel(pll_use),
		.clk_out(p2_y),
		.cur_sel(p2_cur)
	);

	ocs_clk_switch u_path3x (
		.clk(clk),
		.rst(rst),
		.src0(ref_clk),
		.src1(s.d3_out),
		.sel(pll_use),
		.clk_out(p3_y),
		.cur_sel(p3_cur)
	);

	always_comb begin
		next_s = s;
		ref_rise = ref_clk && !s.ref_q;
		vco_rise = vco && !s.vco_q;
		wr_go = s.aw_held && s.w_held && !s.bvalid;
		sts_set = 3'h0;
		sts_clr = 3'h0;
		div_step = 6'h00;

		if (awvalid && s.awready) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata = wdata;
			next_s.wlane0 = wstrb[0];
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_go) begin
			next_s.aw_held = 1'b0;
			next_s.w_held = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = ocs_mapped(s.awaddr) ? ocs_pkg::RESP_OKAY :
				ocs_pkg::RESP_SLVERR;
			if (s.wlane0) begin
				case (s.awaddr)
				ocs_pkg::REG_CTRL: begin
					next_s.pll_sel = s.wdata[ocs_pkg::CTRL_PLL_SEL];
					next_s.pll_pd = s.wdata[ocs_pkg::CTRL_PLL_PD];
					next_s.ps = s.wdata[ocs_pkg::CTRL_PS_LSB +: 3];
				end
				ocs_pkg::REG_OSC: begin
					next_s.osc_ext = s.wdata[ocs_pkg::OSC_EXT];
					next_s.osc_pd = s.wdata[ocs_pkg::OSC_PD];
					next_s.osc_stby = s.wdata[ocs_pkg::OSC_STBY];
				end
				ocs_pkg::REG_STATUS: sts_clr = s.wdata[2:0];
				ocs_pkg::REG_MASK: next_s.mask = s.wdata[2:0];
				ocs_pkg::REG_SHUTDN: next_s.sdn_en = s.wdata[ocs_pkg::SDN_EN];
				default: sts_clr = 3'h0;
				endcase
			end
		end
		next_s.awready = !next_s.aw_held && !next_s.bvalid;
		next_s.wready = !next_s.w_held && !next_s.bvalid;

		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (arvalid && s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = ocs_mapped(araddr) ? ocs_pkg::RESP_OKAY :
				ocs_pkg::RESP_SLVERR;
			next_s.rdata = 32'h00000000;
			case (araddr)
			ocs_pkg::REG_CTRL: begin
				next_s.rdata[ocs_pkg::CTRL_PLL_SEL] = s.pll_sel;
				next_s.rdata[ocs_pkg::CTRL_PLL_PD] = s.pll_pd;
				next_s.rdata[ocs_pkg::CTRL_PS_LSB +: 3] = s.ps;
			end
			ocs_pkg::REG_OSC: begin
				next_s.rdata[ocs_pkg::OSC_EXT] = s.osc_ext;
				next_s.rdata[ocs_pkg::OSC_PD] = s.osc_pd;
				next_s.rdata[ocs_pkg::OSC_STBY] = s.osc_stby;
			end
			ocs_pkg::REG_STATUS: begin
				next_s.rdata[2:0] = s.sts;
				next_s.rdata[ocs_pkg::ST_LIVE_LOCK] = pll_lock_in;
				next_s.rdata[ocs_pkg::ST_REF_EXT] = ref_cur;
				next_s.rdata[ocs_pkg::ST_PLL_ON] = p2_cur;
				next_s.rdata[ocs_pkg::ST_SHUT] = s.shut;
			end
			ocs_pkg::REG_MASK: next_s.rdata[2:0] = s.mask;
			ocs_pkg::REG_SHUTDN: next_s.rdata[ocs_pkg::SDN_EN] = s.sdn_en;
			default: next_s.rdata = 32'h00000000;
			endcase
		end
		next_s.arready = !next_s.rvalid;

		// Reference watchdog: counts cycles since the last reference edge.
		next_s.ref_q = ref_clk;
		if (ref_rise) begin
			next_s.lor_cnt = 6'h00;
		end else if (s.lor_cnt < ocs_pkg::LOR_LIMIT) begin
			next_s.lor_cnt = s.lor_cnt + 6'h01;
			if (s.lor_cnt == ocs_pkg::LOR_LIMIT - 6'h01) begin
				sts_set[ocs_pkg::ST_REFLOST] = 1'b1;
			end
		end
		next_s.lock_q = pll_lock_in;
		sts_set[ocs_pkg::ST_LOCK] = pll_lock_in && !s.lock_q;
		sts_set[ocs_pkg::ST_UNLOCK] = !pll_lock_in && s.lock_q;
		// A new event wins over a clear in the same cycle.
		next_s.sts = (s.sts & ~sts_clr) | sts_set;
		next_s.shut = s.sdn_en && next_s.sts[ocs_pkg::ST_REFLOST];
		next_s.irq = |(next_s.sts & next_s.mask);

		// The VCO runs at eight times the reference; sets the ceiling.
		next_s.vco_q = vco;
		div_step = ocs_div(vco, vco_rise, s.ps, s.d2_out, s.d2_cnt);
		next_s.d2_out = div_step[5];
		next_s.d2_cnt = div_step[4:0];
		next_s.v3_q = vco3;
		div_step = ocs_div(vco3, vco3 && !s.v3_q, s.ps, s.d3_out, s.d3_cnt);
		next_s.d3_out = div_step[5];
		next_s.d3_cnt = div_step[4:0];
		// A stopped VCO would freeze a divider high and trap the path.
		if (s.pll_pd) begin
			next_s.d2_out = 1'b0;
			next_s.d2_cnt = 5'h00;
			next_s.d3_out = 1'b0;
			next_s.d3_cnt = 5'h00;
		end

		// The integration unit halves sys2x itself for a 50% duty cycle.
		next_s.sys2x = p2_y && !s.shut;
		next_s.t3x = p3_y && !s.shut;
		next_s.oscclk = ref_clk;
		if (next_s.sys2x && !s.sys2x) begin
			next_s.adc = !s.adc;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.pll_sel <= ocs_pkg::RST_PLL_SEL;
			s.pll_pd <= ocs_pkg::RST_PLL_PD;
			s.ps <= ocs_pkg::RST_PS;
			s.osc_ext <= ocs_pkg::RST_OSC_EXT;
		end else begin
			s <= next_s;
		end
	end

	assign awready = s.awready;
	assign wready = s.wready;
	assign bresp = s.bresp;
	assign bvalid = s.bvalid;
	assign arready = s.arready;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign rvalid = s.rvalid;
	assign sys2x_clk = s.sys2x;
	assign timer_clk3x = s.t3x;
	assign osc_clk_out = s.oscclk;
	assign adc_clk = s.adc;
	assign hsp_clk = s.sys2x;
	assign osc_powerdown = s.osc_pd;
	assign osc_standby = s.osc_stby;
	assign pll_powerdown = s.pll_pd;
	assign irq = s.irq;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence lock_rise_s;
		!s.lock_q ##1 s.lock_q;
	endsequence
	sequence ref_silent_s;
		(s.lor_cnt == ocs_pkg::LOR_LIMIT - 6'h01) && !ref_rise;
	endsequence

	reset_int_ref_a: assert property ($fell(rst) |-> !s.osc_ext && !ref_cur)
		else $error("Reference is not internal after reset.");
	ext_sel_write_a: assert property (
		$changed(s.osc_ext) |-> $past(wr_go) &&
		$past(s.awaddr) == ocs_pkg::REG_OSC)
		else $error("External select changed without a write.");
	bypass_follow_a: assert property (
		$past(!p2_cur && u_path2x.s.st == ocs_pkg::OCS_SW_RUN, 2) &&
		$past(!s.shut) |-> s.sys2x == $past(ref_clk, 2))
		else $error("Bypass clock does not follow the reference.");
	post_div_a: assert property (
		$changed(s.d2_out) |-> $past(vco_rise) || $past(s.ps == 3'h0) ||
		$past(s.pll_pd))
		else $error("Postscaler output moved without a VCO edge.");
	lock_event_a: assert property (lock_rise_s |-> s.sts[ocs_pkg::ST_LOCK])
		else $error("Lock event did not set its status bit.");
	ref_loss_a: assert property (
		ref_silent_s |=> s.sts[ocs_pkg::ST_REFLOST] ##1 (s.shut == s.sdn_en ||
		!s.sts[ocs_pkg::ST_REFLOST]))
		else $error("Loss of reference was not flagged.");
	shutdown_gate_a: assert property (s.shut |=> !s.sys2x && !s.t3x)
		else $error("Clocks still run during shutdown.");
	pll_off_path_a: assert property (
		s.pll_pd [*3] |=> !p2_cur && !s.d2_out && !s.d3_out)
		else $error("PLL path chosen while powered down.");
	irq_level_a: assert property (s.irq == |(s.sts & s.mask))
		else $error("Interrupt does not match unmasked status.");
	adc_rate_a: assert property ($changed(s.adc) |-> $rose(s.sys2x))
		else $error("ADC clock moved without a sys2x rise.");
endmodule : ocs_clock_synth

// ===== verification/ocs_sim_model.sv
// Model of the system integration unit that halves the double-rate clock.
`timescale 1ns/1ns
module ocs_sim_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic sys2x_clk,
	output logic sys_clk,
	output logic [15:0] sys_rises
);
	logic prev;
	always_ff @(posedge clk) begin
		prev <= sys2x_clk;
		if (rst) begin
			sys_clk <= 1'h0;
			sys_rises <= 16'h0;
		end else if (sys2x_clk && !prev) begin
			sys_clk <= ~sys_clk;
			if (!sys_clk) sys_rises <= sys_rises + 16'h1;
		end
	end
endmodule : ocs_sim_model

// ===== verification/tb_top.sv
// Self-checking bench of the clock synthesis control block.
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rv;
	logic osc_int_in = 1'h0, ext_clock_in = 1'h0, pll_lock_in = 1'h0;
	logic pll_vco_in = 1'h0, pll_3x_in = 1'h0;
	logic sys2x_clk, timer_clk3x, osc_clk_out, adc_clk, hsp_clk, irq;
	logic osc_powerdown, osc_standby, pll_powerdown, sys_clk;
	logic [15:0] sys_rises;
	logic [3:0] prev = 4'h0;
	logic [3:0] sig;
	int n_fail = 0, tests_run = 0, cyc = 0, hw = 0, min_hw = 99, ms;
	int cnt[4] = '{0, 0, 0, 0};
	int m[4];

	assign sig = {osc_clk_out, adc_clk, timer_clk3x, sys2x_clk};
	always #25 clk = ~clk;

	ocs_clock_synth i_dut (.clk(clk), .rst(rst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .osc_int_in(osc_int_in),
		.ext_clock_in(ext_clock_in), .pll_vco_in(pll_vco_in),
		.pll_3x_in(pll_3x_in), .pll_lock_in(pll_lock_in),
		.sys2x_clk(sys2x_clk), .timer_clk3x(timer_clk3x),
		.osc_clk_out(osc_clk_out), .adc_clk(adc_clk), .hsp_clk(hsp_clk),
		.osc_powerdown(osc_powerdown), .osc_standby(osc_standby),
		.pll_powerdown(pll_powerdown), .irq(irq));
	ocs_sim_model i_sim (.clk(clk), .rst(rst), .sys2x_clk(sys2x_clk),
		.sys_clk(sys_clk), .sys_rises(sys_rises));

	// Reference period 4 cycles, external 6 cycles, VCO 2 cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		pll_vco_in <= ~pll_vco_in;
		pll_3x_in <= ~pll_3x_in;
		if (cyc % 2 == 0) osc_int_in <= ~osc_int_in;
		if (cyc % 3 == 0) ext_clock_in <= ~ext_clock_in;
		if (cyc > 8000) begin
			n_fail++;
			$display("ERROR timeout expected %0d seen %0d", 8000, cyc);
			conclude();
		end
	end

	always @(posedge clk) begin
		prev <= sig;
		for (int i = 0; i < 4; i++) begin
			if (sig[i] && !prev[i]) cnt[i] <= cnt[i] + 1;
		end
		hw <= sys2x_clk ? hw + 1 : 0;
		if (!sys2x_clk && prev[0] && hw < min_hw) min_hw <= hw;
		if (hsp_clk !== sys2x_clk) begin
			n_fail++;
			$display("ERROR hsp_clk expected %0h seen %0h", sys2x_clk, hsp_clk);
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g, input int tol);
		tests_run++;
		if ($isunknown(g) ||
			!(g === e || (tol > 0 && g + tol >= e && g <= e + tol))) begin
			n_fail++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, done;
		ta = 1'h0;
		tw = 1'h0;
		done = 1'h0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!done) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			done = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'h0;
			if (tw) wvalid <= 1'h0;
		end
		bready <= 1'h0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic ta, done;
		ta = 1'h0;
		done = 1'h0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!done) begin
			@(negedge clk);
			ta = arvalid && arready;
			done = rvalid;
			rv = rdata;
			resp = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'h0;
		end
		rready <= 1'h0;
		@(posedge clk);
	endtask : rd

	task automatic wrok(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		chk("bresp", ocs_pkg::RESP_OKAY, resp, 0);
	endtask : wrok

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk("rdata", e, rv, 0);
		chk("rresp", ocs_pkg::RESP_OKAY, resp, 0);
	endtask : rchk

	task automatic meas(input int n);
		int b[4];
		int y;
		b = cnt;
		y = sys_rises;
		repeat (n) @(posedge clk);
		for (int i = 0; i < 4; i++) m[i] = cnt[i] - b[i];
		ms = sys_rises - y;
	endtask : meas

	task automatic conclude();
		$display("Comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		repeat (2) @(posedge clk);
		rchk(ocs_pkg::REG_CTRL, 32'h2);
		rchk(ocs_pkg::REG_OSC, 32'h0);
		rchk(ocs_pkg::REG_STATUS, 32'h0);
		chk("pll_powerdown", 1'h1, pll_powerdown, 0);
		rd(8'h14);
		chk("unmapped rresp", ocs_pkg::RESP_SLVERR, resp, 0);
		chk("unmapped rdata", 32'h0, rv, 0);
		wr(8'h14, 32'hFF);
		chk("unmapped bresp", ocs_pkg::RESP_SLVERR, resp, 0);
		meas(64);
		chk("bypass sys2x", 16, m[0], 1);
		chk("bypass timer", 16, m[1], 1);
		chk("adc", 8, m[2], 1);
		chk("osc out", 16, m[3], 1);
		chk("sys clock", 8, ms, 1);
		$display("Done: reset, map and bypass");
		min_hw = 99;
		wrok(ocs_pkg::REG_OSC, 32'h1);
		repeat (20) @(posedge clk);
		meas(60);
		chk("ext sys2x", 10, m[0], 1);
		rchk(ocs_pkg::REG_STATUS, 32'h200);
		chk("min high", 1'h1, min_hw >= 2, 0);
		$display("Done: external reference");
		wrok(ocs_pkg::REG_MASK, 32'h7);
		pll_lock_in <= 1'h1;
		repeat (3) @(posedge clk);
		chk("irq lock", 1'h1, irq, 0);
		rchk(ocs_pkg::REG_STATUS, 32'h301);
		wrok(ocs_pkg::REG_STATUS, 32'h1);
		repeat (2) @(posedge clk);
		chk("irq cleared", 1'h0, irq, 0);
		wrok(ocs_pkg::REG_OSC, 32'h0);
		for (int c = 0; c < 7; c++) begin
			wrok(ocs_pkg::REG_CTRL, (c << 2) | 1);
			repeat (40) @(posedge clk);
			meas(128);
			chk("pll sys2x", 64 >> (c > 5 ? 5 : c), m[0], 1);
			chk("pll timer", 64 >> (c > 5 ? 5 : c), m[1], 1);
		end
		chk("pll_powerdown", 1'h0, pll_powerdown, 0);
		rchk(ocs_pkg::REG_STATUS, 32'h500);
		$display("Done: pll postscaler");
		wrok(ocs_pkg::REG_MASK, 32'h0);
		pll_lock_in <= 1'h0;
		repeat (40) @(posedge clk);
		chk("irq masked", 1'h0, irq, 0);
		rchk(ocs_pkg::REG_STATUS, 32'h2);
		wrok(ocs_pkg::REG_MASK, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq unmasked", 1'h1, irq, 0);
		wrok(ocs_pkg::REG_STATUS, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq w1c", 1'h0, irq, 0);
		$display("Done: interrupt mask");
		wrok(ocs_pkg::REG_CTRL, 32'h2);
		chk("pll_powerdown", 1'h1, pll_powerdown, 0);
		wrok(ocs_pkg::REG_OSC, 32'h4);
		chk("osc_standby", 1'h1, osc_standby, 0);
		wrok(ocs_pkg::REG_OSC, 32'h0);
		wrok(ocs_pkg::REG_STATUS, 32'h7);
		wrok(ocs_pkg::REG_SHUTDN, 32'h1);
		wrok(ocs_pkg::REG_OSC, 32'h2);
		chk("osc_powerdown", 1'h1, osc_powerdown, 0);
		repeat (30) @(posedge clk);
		rchk(ocs_pkg::REG_STATUS, 32'h804);
		meas(40);
		chk("shut sys2x", 0, m[0], 0);
		chk("irq lost", 1'h1, irq, 0);
		wrok(ocs_pkg::REG_OSC, 32'h0);
		wrok(ocs_pkg::REG_STATUS, 32'h4);
		repeat (20) @(posedge clk);
		meas(64);
		chk("resumed sys2x", 16, m[0], 1);
		rchk(ocs_pkg::REG_STATUS, 32'h0);
		$display("Done: power and shutdown");
		conclude();
	end
endmodule : tb_top
